// >>> include/dlsm_regs.svh
// Register offsets, reset values and field sizes of the descriptor list maps
`ifndef DLSM_REGS_SVH
`define DLSM_REGS_SVH

`define DLSM_ADDR_W        10
`define DLSM_DATA_W        32
`define DLSM_SLOT_W        5
`define DLSM_SLOTS         32

`define DLSM_ISO_DONE_OFS  10'h130
`define DLSM_ISO_SKIP_OFS  10'h134
`define DLSM_ISO_LAST_OFS  10'h138
`define DLSM_INTR_DONE_OFS 10'h140
`define DLSM_INTR_SKIP_OFS 10'h144
`define DLSM_INTR_LAST_OFS 10'h148
`define DLSM_ASYNC_DONE_OFS 10'h150
`define DLSM_ASYNC_SKIP_OFS 10'h154

`define DLSM_DONE_RST      32'h0000_0000
`define DLSM_SKIP_RST      32'hFFFF_FFFF
`define DLSM_LAST_RST      32'h0000_0000
`define DLSM_NO_LAST       32'h0000_0000

`endif

// >>> include/dlsm_pkg.sv
// Types shared by the descriptor list map block
`default_nettype none
package dlsm_pkg;

  // Slot offered by a scanner to the descriptor engine
  typedef struct packed {
    logic       valid;
    logic [4:0] slot;
  } dlsm_offer_t;

  // Engine answer for one category
  typedef struct packed {
    logic       ack;
    logic       done;
    logic [4:0] done_slot;
  } dlsm_event_t;

  typedef enum logic [1:0] {
    DLSM_ST_IDLE  = 2'b00,
    DLSM_ST_SEEK  = 2'b01,
    DLSM_ST_OFFER = 2'b10
  } dlsm_scan_st_t;

endpackage
`default_nettype wire

// >>> logic/dlsm_done_map.sv
// Completion map with read-to-clear and set priority
`timescale 1ns/10ps
`default_nettype none
`include "dlsm_regs.svh"
module dlsm_done_map
  import dlsm_pkg::*;
(
  input  wire logic        i_core_clk,
  input  wire logic        i_rstn,
  input  wire dlsm_event_t i_event,
  input  wire logic        i_rd_clr,
  output var  logic [31:0] o_map
);

  logic [31:0] map_reg;
  logic [31:0] map_next;
  logic [31:0] set_vec;

  always_comb begin
    set_vec = '0;
    if (i_event.done) begin
      set_vec[i_event.done_slot] = 1'b1;
    end
    map_next = map_reg;
    if (i_rd_clr) begin
      map_next = '0;
    end
    map_next = map_next | set_vec;
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      map_reg <= `DLSM_DONE_RST;
    end else begin
      map_reg <= map_next;
    end
  end

  assign o_map = map_reg;

endmodule // dlsm_done_map
`default_nettype wire

// >>> logic/dlsm_scanner.sv
// Slot scanner for one category: skips, wraps at the last-slot marker
`timescale 1ns/10ps
`default_nettype none
`include "dlsm_regs.svh"
module dlsm_scanner
  import dlsm_pkg::*;
(
  input  wire logic        i_core_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_scan_en,
  input  wire logic [31:0] i_skip_map,
  input  wire logic [31:0] i_last_map,
  input  wire logic        i_ack,
  output var  dlsm_offer_t o_offer
);

  dlsm_scan_st_t st_reg;
  dlsm_scan_st_t st_next;
  logic [4:0]    slot_reg;
  logic [4:0]    slot_next;
  logic          valid_reg;
  logic          valid_next;

  // Sequential successor; link fields play no part
  function automatic logic [4:0] next_slot(input logic [4:0] cur, input logic [31:0] last);
    if (last[cur] || cur == 5'h1F) begin
      next_slot = 5'h00;
    end else begin
      next_slot = cur + 5'h01;
    end
  endfunction

  always_comb begin
    st_next   = st_reg;
    slot_next = slot_reg;
    case (st_reg)
      DLSM_ST_IDLE: begin
        slot_next = 5'h00;
        if (i_scan_en) begin
          st_next = DLSM_ST_SEEK;
        end
      end
      DLSM_ST_SEEK: begin
        if (!i_scan_en) begin
          st_next = DLSM_ST_IDLE;
        end else if (i_skip_map[slot_reg]) begin
          slot_next = next_slot(slot_reg, i_last_map);
        end else begin
          st_next = DLSM_ST_OFFER;
        end
      end
      DLSM_ST_OFFER: begin
        if (!i_scan_en) begin
          st_next = DLSM_ST_IDLE;
        end else if (i_ack || i_skip_map[slot_reg]) begin
          slot_next = next_slot(slot_reg, i_last_map);
          st_next   = DLSM_ST_SEEK;
        end
      end
      default: begin
        st_next   = DLSM_ST_IDLE;
        slot_next = 5'h00;
      end
    endcase
    // Offer flag registered so the top output comes from a flop
    valid_next = (st_next == DLSM_ST_OFFER);
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_reg    <= DLSM_ST_IDLE;
      slot_reg  <= 5'h00;
      valid_reg <= 1'b0;
    end else begin
      st_reg    <= st_next;
      slot_reg  <= slot_next;
      valid_reg <= valid_next;
    end
  end

  assign o_offer.valid = valid_reg;
  assign o_offer.slot  = slot_reg;

endmodule // dlsm_scanner
`default_nettype wire

// >>> logic/dlsm_list_maps.sv
// Register bank of completion and skip maps for three categories and last-slot maps for iso and intr
`timescale 1ns/10ps
`default_nettype none
`include "dlsm_regs.svh"
module dlsm_list_maps
  import dlsm_pkg::*;
(
  input  wire logic        i_core_clk,
  input  wire logic        i_rstn,
  // Processor register port
  input  wire logic        i_cs,
  input  wire logic        i_rd,
  input  wire logic        i_wr,
  input  wire logic [9:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  output var  logic [31:0] o_rdata,
  output var  logic        o_rvalid,
  // Scan enables from controller schedule
  input  wire logic        i_iso_scan_en,
  input  wire logic        i_intr_scan_en,
  input  wire logic        i_async_scan_en,
  // Descriptor engine answers
  input  wire dlsm_event_t i_iso_event,
  input  wire dlsm_event_t i_intr_event,
  input  wire dlsm_event_t i_async_event,
  // Slots offered to the descriptor engine
  output var  dlsm_offer_t o_iso_offer,
  output var  dlsm_offer_t o_intr_offer,
  output var  dlsm_offer_t o_async_offer
);

  logic [31:0] iso_skip_reg;
  logic [31:0] iso_skip_next;
  logic [31:0] intr_skip_reg;
  logic [31:0] intr_skip_next;
  logic [31:0] async_skip_reg;
  logic [31:0] async_skip_next;
  logic [31:0] iso_last_reg;
  logic [31:0] iso_last_next;
  logic [31:0] intr_last_reg;
  logic [31:0] intr_last_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic        rvalid_reg;
  logic        rvalid_next;

  logic [31:0] iso_done;
  logic [31:0] intr_done;
  logic [31:0] async_done;
  logic        iso_rd_clr;
  logic        intr_rd_clr;
  logic        async_rd_clr;
  logic        rd_strobe;
  logic        wr_strobe;

  // Address match for one register
  function automatic logic hit(input logic [9:0] addr, input logic [9:0] ofs);
    hit = (addr == ofs);
  endfunction

  assign rd_strobe = i_cs && i_rd;
  assign wr_strobe = i_cs && i_wr;

  assign iso_rd_clr   = rd_strobe && hit(i_addr, `DLSM_ISO_DONE_OFS);
  assign intr_rd_clr  = rd_strobe && hit(i_addr, `DLSM_INTR_DONE_OFS);
  assign async_rd_clr = rd_strobe && hit(i_addr, `DLSM_ASYNC_DONE_OFS);

  // Writable maps
  always_comb begin
    iso_skip_next   = iso_skip_reg;
    intr_skip_next  = intr_skip_reg;
    async_skip_next = async_skip_reg;
    iso_last_next   = iso_last_reg;
    intr_last_next  = intr_last_reg;
    if (wr_strobe) begin
      if (hit(i_addr, `DLSM_ISO_SKIP_OFS)) begin
        iso_skip_next = i_wdata;
      end
      if (hit(i_addr, `DLSM_INTR_SKIP_OFS)) begin
        intr_skip_next = i_wdata;
      end
      if (hit(i_addr, `DLSM_ASYNC_SKIP_OFS)) begin
        async_skip_next = i_wdata;
      end
      if (hit(i_addr, `DLSM_ISO_LAST_OFS)) begin
        iso_last_next = i_wdata;
      end
      if (hit(i_addr, `DLSM_INTR_LAST_OFS)) begin
        intr_last_next = i_wdata;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      iso_skip_reg   <= `DLSM_SKIP_RST;
      intr_skip_reg  <= `DLSM_SKIP_RST;
      async_skip_reg <= `DLSM_SKIP_RST;
      iso_last_reg   <= `DLSM_LAST_RST;
      intr_last_reg  <= `DLSM_LAST_RST;
    end else begin
      iso_skip_reg   <= iso_skip_next;
      intr_skip_reg  <= intr_skip_next;
      async_skip_reg <= async_skip_next;
      iso_last_reg   <= iso_last_next;
      intr_last_reg  <= intr_last_next;
    end
  end

  // Read path; unmapped offsets return zero
  always_comb begin
    rvalid_next = rd_strobe;
    rdata_next  = '0;
    if (rd_strobe) begin
      case (i_addr)
        `DLSM_ISO_DONE_OFS:   rdata_next = iso_done;
        `DLSM_ISO_SKIP_OFS:   rdata_next = iso_skip_reg;
        `DLSM_ISO_LAST_OFS:   rdata_next = iso_last_reg;
        `DLSM_INTR_DONE_OFS:  rdata_next = intr_done;
        `DLSM_INTR_SKIP_OFS:  rdata_next = intr_skip_reg;
        `DLSM_INTR_LAST_OFS:  rdata_next = intr_last_reg;
        `DLSM_ASYNC_DONE_OFS: rdata_next = async_done;
        `DLSM_ASYNC_SKIP_OFS: rdata_next = async_skip_reg;
        default:              rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rdata_reg  <= 32'h0000_0000;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg  <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  assign o_rdata  = rdata_reg;
  assign o_rvalid = rvalid_reg;

  // Completion maps
  dlsm_done_map u_iso_done (
    .i_core_clk (i_core_clk),
    .i_rstn     (i_rstn),
    .i_event    (i_iso_event),
    .i_rd_clr   (iso_rd_clr),
    .o_map      (iso_done)
  );

  dlsm_done_map u_intr_done (
    .i_core_clk (i_core_clk),
    .i_rstn     (i_rstn),
    .i_event    (i_intr_event),
    .i_rd_clr   (intr_rd_clr),
    .o_map      (intr_done)
  );

  dlsm_done_map u_async_done (
    .i_core_clk (i_core_clk),
    .i_rstn     (i_rstn),
    .i_event    (i_async_event),
    .i_rd_clr   (async_rd_clr),
    .o_map      (async_done)
  );

  // Scanners
  dlsm_scanner u_iso_scan (
    .i_core_clk (i_core_clk),
    .i_rstn     (i_rstn),
    .i_scan_en  (i_iso_scan_en),
    .i_skip_map (iso_skip_reg),
    .i_last_map (iso_last_reg),
    .i_ack      (i_iso_event.ack),
    .o_offer    (o_iso_offer)
  );

  dlsm_scanner u_intr_scan (
    .i_core_clk (i_core_clk),
    .i_rstn     (i_rstn),
    .i_scan_en  (i_intr_scan_en),
    .i_skip_map (intr_skip_reg),
    .i_last_map (intr_last_reg),
    .i_ack      (i_intr_event.ack),
    .o_offer    (o_intr_offer)
  );

  // Async category has no last-slot map here: full 32-slot pass
  dlsm_scanner u_async_scan (
    .i_core_clk (i_core_clk),
    .i_rstn     (i_rstn),
    .i_scan_en  (i_async_scan_en),
    .i_skip_map (async_skip_reg),
    .i_last_map (`DLSM_NO_LAST),
    .i_ack      (i_async_event.ack),
    .o_offer    (o_async_offer)
  );

endmodule // dlsm_list_maps
`default_nettype wire

// >>> dv/dlsm_list_maps_monitor.sv
// Checker of the register port and the iso scanner
`timescale 1ns/10ps
`default_nettype none
module dlsm_mon
  import dlsm_pkg::*;
(
  input wire logic        i_core_clk,
  input wire logic        i_rstn,
  input wire logic        i_cs,
  input wire logic        i_rd,
  input wire logic        i_wr,
  input wire logic [9:0]  i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic [31:0] o_rdata,
  input wire logic        o_rvalid,
  input wire logic        i_iso_scan_en,
  input wire dlsm_event_t i_iso_event,
  input wire dlsm_offer_t o_iso_offer
);
  logic [31:0] skip_reg, skip_next, last_reg, last_next, skq_reg;
  logic        rdi, ack;
  assign rdi = i_cs && i_rd && i_addr == 10'h130;
  assign ack = o_iso_offer.valid && i_iso_event.ack;
  // Mirror of the iso skip and last maps
  always_comb begin
    skip_next = skip_reg;
    last_next = last_reg;
    if (i_cs && i_wr && i_addr == 10'h134) skip_next = i_wdata;
    if (i_cs && i_wr && i_addr == 10'h138) last_next = i_wdata;
  end
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      skip_reg <= 32'hFFFF_FFFF;
      skq_reg  <= 32'hFFFF_FFFF;
      last_reg <= 32'h0000_0000;
    end else begin
      skip_reg <= skip_next;
      skq_reg  <= skip_reg;
      last_reg <= last_next;
    end
  end
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  a_read_answer: assert property (i_cs && i_rd |=> o_rvalid)
    else $error("read not answered");
  a_no_extra: assert property (!(i_cs && i_rd) |=> !o_rvalid && o_rdata == 32'h0)
    else $error("unexpected read data");
  a_clear_on_read: assert property (rdi && !i_iso_event.done ##1 rdi |=> o_rdata == 32'h0)
    else $error("map not cleared by read");
  a_done_sets_bit: assert property (i_iso_event.done && !rdi ##1 rdi
    |=> o_rdata[$past(i_iso_event.done_slot, 2)])
    else $error("done bit missing");
  a_done_beats_clear: assert property (i_iso_event.done && rdi ##1 rdi
    |=> o_rdata[$past(i_iso_event.done_slot, 2)])
    else $error("done lost to clear");
  a_skip_honoured: assert property (o_iso_offer.valid |-> !skq_reg[o_iso_offer.slot])
    else $error("skipped slot offered");
  a_ack_drops: assert property (ack |=> !o_iso_offer.valid)
    else $error("offer held after ack");
  a_next_slot: assert property (ack && !last_reg[o_iso_offer.slot] && o_iso_offer.slot != 5'h1F
    |=> o_iso_offer.slot == $past(o_iso_offer.slot) + 5'h1)
    else $error("scan order broken");
  a_wrap_last: assert property (ack && (last_reg[o_iso_offer.slot] || o_iso_offer.slot == 5'h1F)
    |=> o_iso_offer.slot == 5'h0)
    else $error("no wrap after last slot");
  a_scan_off: assert property (!i_iso_scan_en |=> !o_iso_offer.valid)
    else $error("offer while scan off");
endmodule // dlsm_mon
bind dlsm_list_maps dlsm_mon u_dlsm_mon (.i_core_clk, .i_rstn, .i_cs, .i_rd, .i_wr, .i_addr,
  .i_wdata, .o_rdata, .o_rvalid, .i_iso_scan_en, .i_iso_event, .o_iso_offer);
`default_nettype wire

// >>> dv/dlsm_list_maps_bench.sv
// Self-checking bench of the descriptor list maps
`timescale 1ns/10ps
`default_nettype none
module dlsm_list_maps_bench;
  import dlsm_pkg::*;
  logic        i_core_clk, i_rstn, i_cs, i_rd, i_wr, o_rvalid;
  logic [9:0]  i_addr;
  logic [31:0] i_wdata, o_rdata;
  logic [2:0]  en;
  dlsm_event_t ev [3];
  dlsm_offer_t of [3];
  int          err_count, num_checks;
  dlsm_list_maps u_dlsm_list_maps (.i_core_clk, .i_rstn, .i_cs, .i_rd, .i_wr, .i_addr,
    .i_wdata, .o_rdata, .o_rvalid, .i_iso_scan_en(en[0]), .i_intr_scan_en(en[1]),
    .i_async_scan_en(en[2]), .i_iso_event(ev[0]), .i_intr_event(ev[1]),
    .i_async_event(ev[2]), .o_iso_offer(of[0]), .o_intr_offer(of[1]),
    .o_async_offer(of[2]));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // Bus request is held after return; idle releases it and lets an edge pass
  task automatic idle;
    {i_cs, i_rd, i_wr} = 3'h0;
    @(negedge i_core_clk);
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    {i_cs, i_rd, i_wr} = 3'h5;
    i_addr = a;
    i_wdata = d;
    @(negedge i_core_clk);
  endtask
  task automatic rd(input logic [9:0] a, input logic [31:0] e);
    {i_cs, i_rd, i_wr} = 3'h6;
    i_addr = a;
    @(negedge i_core_clk);
    chk({31'h0, o_rvalid}, 32'h1);
    chk(o_rdata, e);
  endtask
  // Wait for a slot offer, compare it, then acknowledge it
  task automatic offer(input int c, input logic [4:0] s);
    int n;
    n = 0;
    while (of[c].valid !== 1'h1 && n < 80) begin
      @(negedge i_core_clk);
      n++;
    end
    chk({26'h0, of[c]}, {26'h0, 1'h1, s});
    ev[c].ack = 1'h1;
    @(negedge i_core_clk);
    ev[c].ack = 1'h0;
  endtask
  task automatic t_reset;
    rd(10'h130, 32'h0);
    rd(10'h140, 32'h0);
    rd(10'h150, 32'h0);
    rd(10'h134, 32'hFFFF_FFFF);
    rd(10'h144, 32'hFFFF_FFFF);
    rd(10'h154, 32'hFFFF_FFFF);
    rd(10'h138, 32'h0);
    rd(10'h148, 32'h0);
    rd(10'h158, 32'h0);
    rd(10'h3FC, 32'h0);
  endtask
  task automatic t_regs;
    logic [9:0] a [5] = '{10'h134, 10'h144, 10'h154, 10'h138, 10'h148};
    for (int i = 0; i < 5; i++) wr(a[i], 32'hA5C3_0F00 + 32'(i));
    for (int i = 0; i < 5; i++) rd(a[i], 32'hA5C3_0F00 + 32'(i));
    wr(10'h130, 32'hFFFF_FFFF);
    rd(10'h130, 32'h0);
  endtask
  task automatic t_done;
    logic [9:0] b;
    logic [4:0] s;
    for (int c = 0; c < 3; c++) begin
      b = 10'h130 + 10'(16 * c);
      s = 5'(3 + 13 * c);
      ev[c].done = 1'h1;
      ev[c].done_slot = s;
      idle();
      ev[c].done = 1'h0;
      rd(b, 32'h1 << s);
      rd(b, 32'h0);
      ev[c].done = 1'h1;
      ev[c].done_slot = 5'h1F;
      rd(b, 32'h0);
      ev[c].done = 1'h0;
      rd(b, 32'h8000_0000);
      rd(b, 32'h0);
    end
    idle();
  endtask
  task automatic t_scan;
    wr(10'h134, 32'hFFFF_FFFA);
    wr(10'h138, 32'h4);
    idle();
    en[0] = 1'h1;
    offer(0, 5'h0);
    offer(0, 5'h2);
    offer(0, 5'h0);
    en[0] = 1'h0;
    wr(10'h144, 32'h0);
    for (int k = 0; k < 3; k++) begin
      wr(10'h148, 32'h1 << k);
      idle();
      en[1] = 1'h1;
      for (int j = 0; j <= k + 1; j++) offer(1, 5'(j % (k + 1)));
      en[1] = 1'h0;
      @(negedge i_core_clk);
    end
    wr(10'h154, 32'h7FFF_FFFD);
    idle();
    en[2] = 1'h1;
    offer(2, 5'h1);
    offer(2, 5'h1F);
    offer(2, 5'h1);
    en[2] = 1'h0;
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    i_core_clk = 1'h0;
    forever #12.5 i_core_clk = ~i_core_clk;
  end
  initial begin
    #100000;
    err_count++;
    conclude();
  end
  initial begin
    {i_rstn, i_cs, i_rd, i_wr, i_addr, i_wdata, en} = '0;
    ev = '{default: '0};
    repeat (8) @(negedge i_core_clk);
    i_rstn = 1'h1;
    t_reset();
    t_regs();
    t_done();
    t_scan();
    conclude();
  end
endmodule // dlsm_list_maps_bench
`default_nettype wire
